// ==== src/spp_defines.svh ====
// Constants shared by the serial peripheral port.
// Assumes inclusion by bare name from files under src/.
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// ****************************************************************
// Frame and divider sizes
// ****************************************************************
`define SPP_BITS      8
`define SPP_RATE_W    8

// ****************************************************************
// Pin levels
// ****************************************************************
`define SPP_SS_IDLE   1'b1
`define SPP_OE_OFF    1'b0

`endif

// ==== src/spp_pkg.sv ====
// Types for the serial peripheral port.
// Assumes no other package; used by full scope name only.
package spp_pkg;

   // Use of the active-low select pin
   typedef enum logic [1:0] {
      SPP_SS_OFF,
      SPP_SS_SLAVE,
      SPP_SS_GUARD,
      SPP_SS_CS
   } spp_ss_mode_t;

   // Transfer state
   typedef enum logic [1:0] {
      SPP_IDLE,
      SPP_MASTER,
      SPP_SLAVE
   } spp_state_t;

endpackage

// ==== src/spp_clk_div.sv ====
// Half-period tick generator for the master serial clock.
// Assumes rate is held stable while run is high.
`include "spp_defines.svh"

module spp_clk_div #(
   parameter int unsigned W = `SPP_RATE_W
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         run,
   input  wire logic [W-1:0] rate,
   // Half-period pulse
   output logic              tick
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   if (W < 1) begin : g_chk
      $error("spp_clk_div: W must be at least 1");
   end

   // ****************************************************************
   // Divider
   // ****************************************************************
   // rate-programmed divider
   always_comb begin
      tick     = run && (cnt_reg == rate);
      cnt_next = (!run || tick) ? '0 : cnt_reg + W'(1);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   chk_tick_spacing : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (run && tick && rate != '0) |=> !tick)
      else $error("divider ticked on consecutive cycles with nonzero rate");

endmodule

// ==== src/spp_port.sv ====
// Serial peripheral port: master or slave, 3- or 4-line, multi-master guard.
// Assumes all pin inputs are synchronous to ref_clk; the bench resolves pins.
`include "spp_defines.svh"

module spp_port #(
   parameter int unsigned BITS   = `SPP_BITS,
   parameter int unsigned RATE_W = `SPP_RATE_W
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Configuration
   input  wire logic                 cfg_enable,
   input  wire logic                 cfg_master,
   input  wire logic                 cfg_cpol,
   input  wire logic                 cfg_cpha,
   input  spp_pkg::spp_ss_mode_t     cfg_ss_mode,
   input  wire logic                 cfg_cs_level,
   input  wire logic [RATE_W-1:0]    cfg_rate,
   // Data and flags
   input  wire logic [BITS-1:0]      tx_data,
   input  wire logic                 tx_start,
   input  wire logic                 done_clr,
   input  wire logic                 fault_clr,
   output logic      [BITS-1:0]      rx_data,
   output logic                      busy,
   output logic                      done_flag,
   output logic                      fault_flag,
   // Serial clock pin
   input  wire logic                 sclk_in,
   output logic                      sclk_out,
   output logic                      sclk_oe,
   // Master-out data pin
   input  wire logic                 mosi_in,
   output logic                      mosi_out,
   output logic                      mosi_oe,
   // Master-in data pin
   input  wire logic                 miso_in,
   output logic                      miso_out,
   output logic                      miso_oe,
   // Select pin
   input  wire logic                 slave_select_n_in,
   output logic                      slave_select_n_out,
   output logic                      slave_select_n_oe
);

   localparam int unsigned    EW        = $clog2(2 * BITS);
   localparam logic [EW-1:0]  LAST_EDGE = EW'(2 * BITS - 1);

   if (BITS < 2) begin : g_chk
      $error("spp_port: BITS must be at least 2");
   end

   spp_pkg::spp_state_t state_reg;
   spp_pkg::spp_state_t state_next;
   logic [EW-1:0]       edge_reg;
   logic [EW-1:0]       edge_next;
   logic [BITS-1:0]     tx_sh_reg;
   logic [BITS-1:0]     tx_sh_next;
   logic [BITS-1:0]     rx_sh_reg;
   logic [BITS-1:0]     rx_sh_next;
   logic [BITS-1:0]     rx_data_reg;
   logic [BITS-1:0]     rx_data_next;
   logic                sclk_reg;
   logic                sclk_next;
   logic                sclk_prev_reg;
   logic                done_reg;
   logic                done_next;
   logic                fault_reg;
   logic                fault_next;
   logic                busy_reg;
   logic                drive_reg;
   logic                drive_next;
   logic                miso_oe_reg;
   logic                ss_out_reg;
   logic                ss_out_next;
   logic                ss_oe_reg;
   logic                ss_oe_next;
   logic                tick;
   logic                guard_hit;
   logic                slave_sel;
   logic                stay_master;
   logic                stay_slave;
   logic                evt;
   logic                in_bit;
   logic                done_set;

   // ****************************************************************
   // Master clock divider
   // ****************************************************************
   // half period never below one cycle
   spp_clk_div #(
      .W       (RATE_W)
   ) u_div (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .run     (state_reg == spp_pkg::SPP_MASTER),
      .rate    (cfg_rate),
      .tick    (tick)
   );

   // ****************************************************************
   // Select decode
   // ****************************************************************
   always_comb begin
      guard_hit   = cfg_enable && cfg_master && (cfg_ss_mode == spp_pkg::SPP_SS_GUARD)
                    && !slave_select_n_in;
      slave_sel   = (cfg_ss_mode == spp_pkg::SPP_SS_SLAVE) ? !slave_select_n_in : 1'b1;
      // other select uses need no select line
      stay_master = cfg_enable && cfg_master && !guard_hit;
      stay_slave  = cfg_enable && !cfg_master && slave_sel;
      in_bit      = cfg_master ? miso_in : mosi_in;
      // master edges from divider, slave edges from pin
      evt         = ((state_reg == spp_pkg::SPP_MASTER) && stay_master && tick)
                    || ((state_reg == spp_pkg::SPP_SLAVE) && stay_slave
                        && (sclk_in != sclk_prev_reg));
   end

   // ****************************************************************
   // Transfer engine
   // ****************************************************************
   always_comb begin
      state_next   = state_reg;
      edge_next    = edge_reg;
      tx_sh_next   = tx_sh_reg;
      rx_sh_next   = rx_sh_reg;
      rx_data_next = rx_data_reg;
      sclk_next    = sclk_reg;
      done_set     = 1'b0;
      case (state_reg)
         spp_pkg::SPP_IDLE: begin
            sclk_next = cfg_cpol;
            edge_next = '0;
            if (stay_master && tx_start && !fault_reg) begin
               state_next = spp_pkg::SPP_MASTER;
               tx_sh_next = tx_data;
            end else if (stay_slave) begin
               state_next = spp_pkg::SPP_SLAVE;
               tx_sh_next = tx_data;
            end
         end
         spp_pkg::SPP_MASTER: begin
            if (!stay_master) begin
               state_next = spp_pkg::SPP_IDLE;
               sclk_next  = cfg_cpol;
            end else if (tick) begin
               sclk_next = !sclk_reg;
            end
         end
         spp_pkg::SPP_SLAVE: begin
            if (!stay_slave) begin
               state_next = spp_pkg::SPP_IDLE;
            end
         end
         default: begin
            state_next = spp_pkg::SPP_IDLE;
         end
      endcase
      // phase picks sample or drive edge
      if (evt) begin
         if (edge_reg[0] == cfg_cpha) begin
            rx_sh_next = {rx_sh_reg[BITS-2:0], in_bit};
         end else if (!(cfg_cpha && edge_reg == '0)) begin
            tx_sh_next = {tx_sh_reg[BITS-2:0], 1'b0};
         end
         edge_next = edge_reg + EW'(1);
         if (edge_reg == LAST_EDGE) begin
            state_next   = spp_pkg::SPP_IDLE;
            rx_data_next = rx_sh_next;
            done_set     = 1'b1;
         end
      end
   end

   // ****************************************************************
   // Flags and pin drivers
   // ****************************************************************
   always_comb begin
      done_next   = done_set || (done_reg && !done_clr);
      fault_next  = guard_hit || (fault_reg && !fault_clr);
      // master drives only when not overruled
      drive_next  = cfg_enable && cfg_master && !guard_hit && !fault_next;
      ss_oe_next  = cfg_enable && cfg_master && (cfg_ss_mode == spp_pkg::SPP_SS_CS);
      ss_out_next = ss_oe_next ? cfg_cs_level : `SPP_SS_IDLE;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= spp_pkg::SPP_IDLE;
         edge_reg      <= '0;
         tx_sh_reg     <= '0;
         rx_sh_reg     <= '0;
         rx_data_reg   <= '0;
         sclk_reg      <= 1'b0;
         sclk_prev_reg <= 1'b0;
         done_reg      <= 1'b0;
         fault_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         drive_reg     <= `SPP_OE_OFF;
         miso_oe_reg   <= `SPP_OE_OFF;
         ss_out_reg    <= `SPP_SS_IDLE;
         ss_oe_reg     <= `SPP_OE_OFF;
      end else begin
         state_reg     <= state_next;
         edge_reg      <= edge_next;
         tx_sh_reg     <= tx_sh_next;
         rx_sh_reg     <= rx_sh_next;
         rx_data_reg   <= rx_data_next;
         sclk_reg      <= sclk_next;
         sclk_prev_reg <= sclk_in;
         done_reg      <= done_next;
         fault_reg     <= fault_next;
         busy_reg      <= (state_next != spp_pkg::SPP_IDLE);
         drive_reg     <= drive_next;
         miso_oe_reg   <= (state_next == spp_pkg::SPP_SLAVE);
         ss_out_reg    <= ss_out_next;
         ss_oe_reg     <= ss_oe_next;
      end
   end

   assign rx_data            = rx_data_reg;
   assign busy               = busy_reg;
   assign done_flag          = done_reg;
   assign fault_flag         = fault_reg;
   assign sclk_out           = sclk_reg;
   assign sclk_oe            = drive_reg;
   assign mosi_out           = tx_sh_reg[BITS-1];
   assign mosi_oe            = drive_reg;
   assign miso_out           = tx_sh_reg[BITS-1];
   assign miso_oe            = miso_oe_reg;
   assign slave_select_n_out = ss_out_reg;
   assign slave_select_n_oe  = ss_oe_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_guard_fault : assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_hit |=> fault_flag && !sclk_oe && !mosi_oe)
      else $error("guard select did not raise fault and release drivers");

   chk_slave_deselect : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg_ss_mode == spp_pkg::SPP_SS_SLAVE && slave_select_n_in)
      |=> !miso_oe && state_reg != spp_pkg::SPP_SLAVE)
      else $error("slave active while select high");

   chk_cs_follow : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg_enable && cfg_master && cfg_ss_mode == spp_pkg::SPP_SS_CS)
      |=> slave_select_n_oe && slave_select_n_out == $past(cfg_cs_level))
      else $error("chip select output does not follow control level");

   chk_ss_free : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg_ss_mode == spp_pkg::SPP_SS_OFF) |=> !slave_select_n_oe)
      else $error("select pin driven while switched off");

   chk_sclk_on_tick : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == spp_pkg::SPP_MASTER && stay_master && !tick)
      |=> $stable(sclk_out))
      else $error("master clock moved without a divider tick");

   chk_idle_polarity : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == spp_pkg::SPP_IDLE) ##1
      (state_reg == spp_pkg::SPP_IDLE && $stable(cfg_cpol)) |-> sclk_out == cfg_cpol)
      else $error("idle serial clock not at configured polarity");

   chk_frame_done : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (evt && edge_reg == LAST_EDGE)
      |=> done_flag && !busy && rx_data == $past(rx_sh_next))
      else $error("last edge did not complete the frame");

   chk_done_wins : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (done_set && done_clr) |=> done_flag)
      else $error("done event lost against clear");

   chk_master_start : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == spp_pkg::SPP_IDLE && stay_master && tx_start && !fault_reg)
      |=> busy && sclk_oe && mosi_out == $past(tx_data[BITS-1]))
      else $error("master start did not begin a transfer");

   chk_four_wire_slave : assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_reg == spp_pkg::SPP_IDLE && cfg_enable && !cfg_master && slave_sel)
      |=> miso_oe && busy)
      else $error("selected slave did not engage");

endmodule

// ==== testbench/spp_peer.sv ====
// Far-side model: a plain slave, or a slow master that owns the select line.
// Assumes the bench resolves every shared line from all drivers.
module spp_peer (
   // Clock and mode
   input  wire logic ref_clk,
   input  wire logic cpol,
   input  wire logic cpha,
   // Resolved lines
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic miso,
   // Driven lines
   output logic      sclk_o,
   output logic      mosi_o,
   output logic      miso_o,
   output logic      sel_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic       prev_sclk;
   int         drv_cnt;
   int         idx;

   initial begin
      tx_byte = 8'h00;
      rx_byte = 8'h00;
      prev_sclk = 1'b0;
      drv_cnt = 0;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      sel_n_o = 1'b1;
   end

   // ****************************************************************
   // Slave side
   // ****************************************************************
   // sample edge choice
   always @(posedge ref_clk) begin
      if (sclk !== prev_sclk && sclk == (cpol ~^ cpha)) begin
         rx_byte <= {rx_byte[6:0], mosi};
      end else if (sclk !== prev_sclk) begin
         drv_cnt <= drv_cnt + 1;
      end
      prev_sclk <= sclk;
   end

   always_comb begin
      idx = drv_cnt - int'(cpha);
      if (idx < 0) idx = 0;
      if (idx > 7) idx = 7;
      miso_o = tx_byte[7 - idx];
   end

   task automatic arm(input logic [7:0] b);
      tx_byte = b;
      drv_cnt = 0;
      rx_byte = 8'h00;
   endtask

   // ****************************************************************
   // Master side
   // ****************************************************************
   // select line arbitration
   task automatic set_sel(input logic v);
      @(posedge ref_clk);
      sel_n_o <= v;
   endtask

   task automatic xfer(input int h, input logic [7:0] b, output logic [7:0] r);
      r = 8'h00;
      @(posedge ref_clk);
      sclk_o <= cpol;
      @(posedge ref_clk);
      sel_n_o <= 1'b0;
      mosi_o  <= b[7];
      repeat (h) @(posedge ref_clk);
      for (int i = 0; i < 16; i++) begin
         if (i % 2 == int'(cpha)) r = {r[6:0], miso};
         else if (i < 15) mosi_o <= b[7 - (i + 1) / 2];
         sclk_o <= ~sclk_o;
         repeat (h) @(posedge ref_clk);
      end
      sel_n_o <= 1'b1;
   endtask
endmodule

// ==== testbench/spp_port_tb.sv ====
// Self-checking bench for the serial port against the far-side model.
// Assumes spp_pkg and spp_peer are compiled first.
module spp_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  ref_clk, rst_n, cfg_enable, cfg_master, cfg_cpol, cfg_cpha;
   logic                  cfg_cs_level, tx_start, done_clr, fault_clr, busy, done_flag;
   logic                  fault_flag, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out;
   logic                  miso_oe, sel_out, sel_oe, peer_mst, flt, p_sclk, p_mosi, p_miso;
   logic                  p_sel_n;
   logic [7:0]            cfg_rate, tx_data, rx_data, r;
   spp_pkg::spp_ss_mode_t cfg_ss_mode;
   wire                   sclk, mosi, miso, sel_n;
   int                    failures, checks;

   assign sclk  = sclk_oe ? sclk_out : (peer_mst ? p_sclk : flt);
   assign mosi  = mosi_oe ? mosi_out : (peer_mst ? p_mosi : flt);
   assign miso  = miso_oe ? miso_out : (peer_mst ? flt : p_miso);
   assign sel_n = sel_oe ? sel_out : p_sel_n;

   spp_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_enable(cfg_enable),
      .cfg_master(cfg_master), .cfg_cpol(cfg_cpol), .cfg_cpha(cfg_cpha),
      .cfg_ss_mode(cfg_ss_mode), .cfg_cs_level(cfg_cs_level), .cfg_rate(cfg_rate),
      .tx_data(tx_data), .tx_start(tx_start), .done_clr(done_clr), .fault_clr(fault_clr),
      .rx_data(rx_data), .busy(busy), .done_flag(done_flag), .fault_flag(fault_flag),
      .sclk_in(sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi),
      .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
      .miso_oe(miso_oe), .slave_select_n_in(sel_n), .slave_select_n_out(sel_out),
      .slave_select_n_oe(sel_oe));

   spp_peer u_peer (.ref_clk(ref_clk), .cpol(cfg_cpol), .cpha(cfg_cpha), .sclk(sclk),
      .mosi(mosi), .miso(miso), .sclk_o(p_sclk), .mosi_o(p_mosi), .miso_o(p_miso),
      .sel_n_o(p_sel_n));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Released lines show a changing level
   always @(posedge ref_clk) flt <= ~flt;

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (done_flag !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      #1;
      if (n >= 2000) begin
         check_bit("done_flag", 1'b1, done_flag);
         report_and_stop();
      end
   endtask

   task automatic cfg(input logic ms, input spp_pkg::spp_ss_mode_t md, input logic [1:0] m,
                      input logic [7:0] rt);
      @(posedge ref_clk);
      cfg_master  <= ms;
      cfg_ss_mode <= md;
      cfg_cpol    <= m[1];
      cfg_cpha    <= m[0];
      cfg_rate    <= rt;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic kick();
      @(posedge ref_clk);
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      #1;
   endtask

   task automatic clear_flags();
      @(posedge ref_clk);
      done_clr  <= 1'b1;
      fault_clr <= 1'b1;
      @(posedge ref_clk);
      done_clr  <= 1'b0;
      fault_clr <= 1'b0;
      @(posedge ref_clk);
      #1;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_master();
      for (int m = 0; m < 4; m++) begin
         cfg(1'b1, spp_pkg::SPP_SS_OFF, m[1:0], 8'h02);
         tx_data <= 8'ha5 ^ m[7:0];
         check_bit("idle sclk", m[1], sclk);
         check_bit("sel_oe off", 1'b0, sel_oe);
         u_peer.arm(8'h3c + m[7:0]);
         kick();
         check_bit("busy", 1'b1, busy);
         wait_done();
         check_byte("master rx", 8'h3c + m[7:0], rx_data);
         check_byte("peer rx", 8'ha5 ^ m[7:0], u_peer.rx_byte);
         check_bit("busy end", 1'b0, busy);
         clear_flags();
         check_bit("done cleared", 1'b0, done_flag);
      end
      $display("test master done");
   endtask

   task automatic t_rate();
      int n;
      for (int k = 0; k < 2; k++) begin
         cfg(1'b1, spp_pkg::SPP_SS_OFF, 2'b00, 8'(k * 5));
         u_peer.arm(8'h00);
         kick();
         n = 0;
         while (sclk === 1'b0 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         n = 0;
         while (sclk === 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         check_byte("half period", 8'(k * 5 + 1), n[7:0]);
         wait_done();
         clear_flags();
      end
      $display("test rate done");
   endtask

   task automatic t_slave();
      peer_mst <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         cfg(1'b0, spp_pkg::SPP_SS_SLAVE, m[1:0], 8'h00);
         tx_data <= 8'h5a ^ m[7:0];
         check_bit("miso_oe unselected", 1'b0, miso_oe);
         u_peer.xfer(8, 8'hc3 + m[7:0], r);
         wait_done();
         check_byte("slave rx", 8'hc3 + m[7:0], rx_data);
         check_byte("master model rx", 8'h5a ^ m[7:0], r);
         check_bit("slave sclk_oe", 1'b0, sclk_oe);
         clear_flags();
      end
      // Three-line slave: no select, engages as soon as enabled
      tx_data <= 8'h81;
      cfg(1'b0, spp_pkg::SPP_SS_OFF, 2'b11, 8'h00);
      check_bit("3-wire engaged", 1'b1, miso_oe);
      u_peer.xfer(8, 8'h7e, r);
      wait_done();
      check_byte("3-wire slave rx", 8'h7e, rx_data);
      check_byte("3-wire model rx", 8'h81, r);
      clear_flags();
      peer_mst <= 1'b0;
      $display("test slave done");
   endtask

   task automatic t_guard();
      cfg(1'b1, spp_pkg::SPP_SS_GUARD, 2'b00, 8'h03);
      u_peer.arm(8'h96);
      kick();
      repeat (20) @(posedge ref_clk);
      u_peer.set_sel(1'b0);
      repeat (3) @(posedge ref_clk);
      #1;
      check_bit("fault", 1'b1, fault_flag);
      check_bit("guard sclk_oe", 1'b0, sclk_oe);
      check_bit("guard mosi_oe", 1'b0, mosi_oe);
      u_peer.set_sel(1'b1);
      kick();
      check_bit("start refused", 1'b0, busy);
      clear_flags();
      check_bit("fault cleared", 1'b0, fault_flag);
      u_peer.arm(8'h96);
      kick();
      wait_done();
      check_byte("after fault rx", 8'h96, rx_data);
      clear_flags();
      $display("test guard done");
   endtask

   task automatic t_cs();
      for (int v = 0; v < 2; v++) begin
         cfg_cs_level <= v[0];
         cfg(1'b1, spp_pkg::SPP_SS_CS, 2'b00, 8'h02);
         check_bit("cs oe", 1'b1, sel_oe);
         check_bit("cs level", v[0], sel_n);
      end
      cfg(1'b1, spp_pkg::SPP_SS_OFF, 2'b00, 8'h02);
      check_bit("off oe", 1'b0, sel_oe);
      $display("test chip select done");
   endtask

   initial begin
      failures = 0;
      checks = 0;
      flt = 1'b0;
      rst_n = 1'b0;
      cfg_enable = 1'b1;
      cfg_master = 1'b1;
      cfg_cpol = 1'b0;
      cfg_cpha = 1'b0;
      cfg_ss_mode = spp_pkg::SPP_SS_OFF;
      cfg_cs_level = 1'b1;
      cfg_rate = 8'h02;
      tx_data = 8'h00;
      tx_start = 1'b0;
      done_clr = 1'b0;
      fault_clr = 1'b0;
      peer_mst = 1'b0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_master();
      t_rate();
      t_slave();
      t_guard();
      t_cs();
      report_and_stop();
   end
endmodule
